/* File: src/ubr_pkg.sv */
// ubr_pkg: constants, register map and carrier types for the baud generator and receive latch
// assumes a single 200 MHz system clock and a classic wishbone register bus
package ubr_pkg;
	// register byte offsets
	localparam logic [3:0] UBR_ADDR_DIVIDER = 4'h0;
	localparam logic [3:0] UBR_ADDR_MODE    = 4'h4;
	localparam logic [3:0] UBR_ADDR_STATUS  = 4'h8;
	localparam logic [3:0] UBR_ADDR_DATA    = 4'hc;
	// divider control fields
	localparam int SEL_HI_POS = 7;
	localparam int SEL_LO_POS = 6;
	localparam int DIV_MSB    = 4;
	localparam int DIV_LSB    = 0;
	// mode control fields
	localparam int POWER_POS  = 7;
	localparam int RXEN_POS   = 5;
	// reset values
	localparam logic [7:0] DIVIDER_RST = 8'h08;
	localparam logic [7:0] MODE_RST    = 8'h00;
	// division value limits
	localparam logic [4:0] DIV_MIN = 5'h08;
	localparam logic [4:0] DIV_MAX = 5'h1f;
	// frame: start, 8 data, parity, stop
	localparam logic [3:0] FRAME_BITS = 4'hb;
	localparam logic [3:0] STOP_IDX   = 4'ha;
	// base clock prescaler divide exponents per select code
	localparam logic [3:0] PRESC_0 = 4'h1;
	localparam logic [3:0] PRESC_1 = 4'h2;
	localparam logic [3:0] PRESC_2 = 4'h3;
	localparam logic [3:0] PRESC_3 = 4'h4;

	typedef struct packed {
		logic [10:0] frame;
		logic        stop_ok;
		logic        done;
	} ubr_rx_t;
endpackage : ubr_pkg

/* File: src/ubr_core.sv */
// ubr_core: baud rate generator and receive bit latch with wishbone registers
// assumes rxd_i is asynchronous and the bus master is a classic wishbone single cycle
// Functional notes
// - bits 7,6 of divider select base clock
// - division value k valid from 8 to 31
// - bit latch moments come from the counter
// - frame is 11 bits, stop checked
// - two base clock latch margin via filter
// - bit rate is base clock over 2k
// - counter runs from start, halts after frame
// - base clock held off while power is zero
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ubr_core
	import ubr_pkg::*;
(
	// system
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// wishbone slave
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [3:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic [31:0]      DAT_O,
	output logic             ACK_O,
	// serial line
	input  wire logic        RXD_I,
	// status
	output logic             BAUD_TICK_O,
	output logic             RX_DONE_O
);
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS} ubr_state_t;

	logic [7:0]  divider_reg;
	logic [7:0]  mode_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic [3:0]  presc_reg;
	logic        base_en;
	logic        sync1_reg;
	logic        sync2_reg;
	logic        samp_reg;
	logic        filt_reg;
	logic        filt_prev_reg;
	logic [5:0]  cnt_reg;
	logic [3:0]  bit_reg;
	logic [10:0] shift_reg;
	ubr_rx_t     rx_reg;
	logic        sticky_done_reg;
	ubr_state_t  state_reg;
	logic        tx_cnt_tick;
	logic [5:0]  tx_cnt_reg;
	logic [4:0]  k_val;
	logic        power;
	logic        rx_on;
	logic        bus_req;

	assign bus_req = CYC_I & STB_I & ~ack_reg;
	assign power   = mode_reg[POWER_POS];
	assign rx_on   = power & mode_reg[RXEN_POS];
	// clamp k into the valid range
	assign k_val = (divider_reg[DIV_MSB:DIV_LSB] < DIV_MIN) ? DIV_MIN :
		divider_reg[DIV_MSB:DIV_LSB];

	function automatic logic [3:0] presc_mask(input logic [1:0] sel);
		unique case (sel)
			2'h0: presc_mask = PRESC_0;
			2'h1: presc_mask = PRESC_1;
			2'h2: presc_mask = PRESC_2;
			2'h3: presc_mask = PRESC_3;
		endcase
	endfunction : presc_mask

	// register writes
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			divider_reg <= DIVIDER_RST;
			mode_reg    <= MODE_RST;
		end
		else if (bus_req && WE_I && SEL_I[0])
		begin
			if (ADR_I == UBR_ADDR_DIVIDER)
				divider_reg <= DAT_I[7:0];
			if (ADR_I == UBR_ADDR_MODE)
				mode_reg <= DAT_I[7:0];
		end
	end

	// ack and read data; unmapped reads return zero
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
		end
		else
		begin
			ack_reg <= bus_req;
			if (bus_req && !WE_I)
			begin
				unique case (ADR_I)
					UBR_ADDR_DIVIDER: dat_reg <= {24'h0, divider_reg};
					UBR_ADDR_MODE:    dat_reg <= {24'h0, mode_reg};
					UBR_ADDR_STATUS:  dat_reg <= {29'h0, rx_reg.stop_ok, sticky_done_reg,
						state_reg != ST_IDLE};
					UBR_ADDR_DATA:    dat_reg <= {21'h0, rx_reg.frame};
					default:          dat_reg <= 32'h0;
				endcase
			end
		end
	end
	assign ACK_O = ack_reg;
	assign DAT_O = dat_reg;

	// prescaler: base enable pulses at 200MHz / 2^n, held off without power
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			presc_reg <= 4'h0;
		else if (!power)
			presc_reg <= 4'h0;
		else
			presc_reg <= presc_reg + 4'h1;
	end
	always_comb
	begin
		logic [3:0] n;
		n = presc_mask({divider_reg[SEL_HI_POS], divider_reg[SEL_LO_POS]});
		base_en = power && ((presc_reg & ((4'h1 << n) - 4'h1)) == 4'h0);
	end

	// free baud tick for transmit side: one tick per 2k base clocks
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			tx_cnt_reg <= 6'h0;
		else if (!power)
			tx_cnt_reg <= 6'h0;
		else if (base_en)
			tx_cnt_reg <= tx_cnt_tick ? 6'h0 : tx_cnt_reg + 6'h1;
	end
	assign tx_cnt_tick = base_en && (tx_cnt_reg == {k_val, 1'b0} - 6'h1);
	assign BAUD_TICK_O = tx_cnt_tick;

	// two flop synchroniser then two-sample match filter on base clock
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end
		else
		begin
			sync1_reg <= RXD_I;
			sync2_reg <= sync1_reg;
		end
	end
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			samp_reg      <= 1'b1;
			filt_reg      <= 1'b1;
			filt_prev_reg <= 1'b1;
		end
		else if (base_en)
		begin
			samp_reg      <= sync2_reg;
			filt_prev_reg <= filt_reg;
			if (samp_reg == sync2_reg)
				filt_reg <= sync2_reg;
		end
	end

	// receive counter and frame latch
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 6'h0;
			bit_reg   <= 4'h0;
			shift_reg <= 11'h0;
			rx_reg    <= '0;
		end
		else if (!rx_on)
		begin
			state_reg   <= ST_IDLE;
			cnt_reg     <= 6'h0;
			bit_reg     <= 4'h0;
			rx_reg.done <= 1'b0;
		end
		else
		begin
			rx_reg.done <= 1'b0;
			if (base_en)
			begin
				unique case (state_reg)
					ST_IDLE:
						if (filt_prev_reg && !filt_reg)
						begin
							state_reg <= ST_START;
							cnt_reg   <= 6'h1;
						end
					ST_START:
						if (cnt_reg == {1'b0, k_val})
						begin
							// recheck at mid start bit
							if (!filt_reg)
							begin
								state_reg    <= ST_BITS;
								shift_reg[0] <= 1'b0;
								bit_reg      <= 4'h1;
								cnt_reg      <= 6'h1;
							end
							else
								state_reg <= ST_IDLE;
						end
						else
							cnt_reg <= cnt_reg + 6'h1;
					ST_BITS:
						if (cnt_reg == {k_val, 1'b0})
						begin
							// latch at mid bit, 2k after previous latch
							shift_reg[bit_reg] <= filt_reg;
							cnt_reg            <= 6'h1;
							if (bit_reg == STOP_IDX)
							begin
								state_reg      <= ST_IDLE;
								rx_reg.frame   <= {filt_reg, shift_reg[9:0]};
								rx_reg.stop_ok <= filt_reg;
								rx_reg.done    <= 1'b1;
							end
							else
								bit_reg <= bit_reg + 4'h1;
						end
						else
							cnt_reg <= cnt_reg + 6'h1;
					default:
						state_reg <= ST_IDLE;
				endcase
			end
		end
	end
	assign RX_DONE_O = rx_reg.done;

	// sticky done flag, cleared by reading data; set wins
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			sticky_done_reg <= 1'b0;
		else if (rx_reg.done)
			sticky_done_reg <= 1'b1;
		else if (bus_req && !WE_I && ADR_I == UBR_ADDR_DATA)
			sticky_done_reg <= 1'b0;
	end
endmodule : ubr_core
`default_nettype wire

/* File: verif/ubr_sva.sv */
// ubr_sva: bus and timing checks on the ubr_core ports
// assumes one clock domain with an active-high asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module ubr_sva
(
	// watched ports
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic        ACK_O,
	input wire logic [31:0] DAT_O,
	input wire logic        RXD_I,
	input wire logic        BAUD_TICK_O,
	input wire logic        RX_DONE_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	ack_resp_a:
		assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack missing");
	ack_pulse_a:
		assert property (ACK_O |=> !ACK_O) else $error("ack too long");
	ack_held_a:
		assert property (ACK_O |-> CYC_I && STB_I) else $error("ack without request");
	idle_ack_a:
		assert property (!(CYC_I && STB_I) |=> !ACK_O) else $error("ack when idle");
	dat_width_a:
		assert property (ACK_O |-> DAT_O[31:11] == 21'h0) else $error("upper data set");
	tick_gap_a:
		assert property (BAUD_TICK_O |=> !BAUD_TICK_O [*8]) else $error("tick too soon");
	rx_gap_a:
		assert property (RX_DONE_O |=> !RX_DONE_O [*8]) else $error("done too soon");
	line_latch_a:
		assert property ($fell(RXD_I) |=> !RX_DONE_O [*8]) else $error("done off count");
endmodule : ubr_sva
bind ubr_core ubr_sva u_sva (.CLK_I(CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
	.ACK_O(ACK_O), .DAT_O(DAT_O), .RXD_I(RXD_I), .BAUD_TICK_O(BAUD_TICK_O),
	.RX_DONE_O(RX_DONE_O));
`default_nettype wire

/* File: verif/ubr_far_tx.sv */
// ubr_far_tx: remote serial transmitter, one 11-bit frame per request
// assumes go_i is a one-cycle pulse; the line idles high between frames
`timescale 1ns/10ps
`default_nettype none
module ubr_far_tx
(
	// control
	input  wire logic        clk_i,
	input  wire logic        go_i,
	input  wire logic [10:0] frame_i,
	input  wire logic [15:0] bit_clks_i,
	// line
	output logic             txd_o,
	output logic             busy_o
);
	logic [3:0]  idx_reg;
	logic [15:0] cnt_reg;
	initial txd_o = 1'b1;
	initial busy_o = 1'b0;
	always @(posedge clk_i)
	begin
		if (go_i && !busy_o)
		begin
			busy_o  <= 1'b1;
			idx_reg <= 4'h0;
			cnt_reg <= 16'h0;
			txd_o   <= frame_i[0];
		end
		else if (busy_o)
		begin
			cnt_reg <= cnt_reg + 16'h1;
			if (cnt_reg == bit_clks_i - 16'h1)
			begin
				cnt_reg <= 16'h0;
				idx_reg <= idx_reg + 4'h1;
				txd_o   <= (idx_reg == 4'ha) ? 1'b1 : frame_i[idx_reg + 4'h1];
				busy_o  <= (idx_reg != 4'ha);
			end
		end
	end
endmodule : ubr_far_tx
`default_nettype wire

/* File: verif/ubr_core_tb_top.sv */
// ubr_core_tb_top: register, baud and receive tests for ubr_core
// assumes a 200 MHz clock and the ubr_far_tx line model
`timescale 1ns/10ps
`default_nettype none
module ubr_core_tb_top;
	import ubr_pkg::*;
	logic        CLK_I = 1'b0;
	logic        RST_I = 1'b1;
	logic        CYC_I = 1'b0;
	logic        STB_I = 1'b0;
	logic        WE_I = 1'b0;
	logic [3:0]  ADR_I = 4'h0;
	logic [3:0]  SEL_I = 4'h0;
	logic [31:0] DAT_I = 32'h0;
	logic [31:0] DAT_O, q;
	logic        ACK_O, RXD_I, BAUD_TICK_O, RX_DONE_O, busy;
	logic        go = 1'b0;
	logic [10:0] frame = 11'h7ff;
	logic [15:0] bit_clks = 16'h40;
	logic [7:0]  divs [5] = '{8'h08, 8'h49, 8'h9f, 8'hc8, 8'h03};
	int          exps [5] = '{32, 72, 496, 256, 32};
	int          err_total = 0;
	int          compares = 0;
	int          n;
	ubr_core dut (.CLK_I(CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
		.ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
		.RXD_I(RXD_I), .BAUD_TICK_O(BAUD_TICK_O), .RX_DONE_O(RX_DONE_O));
	ubr_far_tx u_far (.clk_i(CLK_I), .go_i(go), .frame_i(frame), .bit_clks_i(bit_clks),
		.txd_o(RXD_I), .busy_o(busy));
	initial forever #2.5 CLK_I = ~CLK_I;
	task automatic tally_and_finish();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic [3:0] a, input logic we, input logic [7:0] d);
		@(posedge CLK_I);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I  <= we;
		ADR_I <= a;
		SEL_I <= 4'hf;
		DAT_I <= {24'h0, d};
		do @(posedge CLK_I); while (ACK_O !== 1'b1);
		q = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
	endtask : wb
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		wb(a, 1'b0, 8'h00);
		chk(q, exp);
	endtask : rd
	task automatic period(input logic [7:0] div, input int exp);
		int c;
		wb(UBR_ADDR_DIVIDER, 1'b1, div);
		repeat (2) do @(posedge CLK_I); while (BAUD_TICK_O !== 1'b1);
		c = 0;
		do begin @(posedge CLK_I); c++; end while (BAUD_TICK_O !== 1'b1);
		chk(32'(c), 32'(exp));
	endtask : period
	task automatic send(input logic [15:0] b, input logic [10:0] f);
		int c;
		while (busy !== 1'b0) @(posedge CLK_I);
		bit_clks <= b;
		frame <= f;
		go <= 1'b1;
		@(posedge CLK_I);
		go <= 1'b0;
		c = 0;
		do begin @(posedge CLK_I); c++; end while (RX_DONE_O !== 1'b1 && c < 2000);
		chk(32'(c < 2000), 32'h1);
		rd(UBR_ADDR_STATUS, {29'h0, f[10], 2'b10});
		rd(UBR_ADDR_DATA, {21'h0, f});
	endtask : send
	initial
	begin
		#100000;
		err_total++;
		tally_and_finish();
	end
	initial
	begin
		repeat (8) @(posedge CLK_I);
		RST_I <= 1'b0;
		rd(UBR_ADDR_DIVIDER, 32'h8);
		rd(UBR_ADDR_MODE, 32'h0);
		rd(4'h2, 32'h0);
		wb(UBR_ADDR_DIVIDER, 1'b1, 8'hd5);
		rd(UBR_ADDR_DIVIDER, 32'hd5);
		$display("test registers done");
		wb(UBR_ADDR_MODE, 1'b1, 8'ha0);
		for (n = 0; n < 5; n++)
			period(divs[n], exps[n]);
		$display("test baud done");
		wb(UBR_ADDR_MODE, 1'b1, 8'h20);
		n = 0;
		repeat (600) @(posedge CLK_I) n += int'(BAUD_TICK_O !== 1'b0);
		chk(32'(n), 32'h0);
		$display("test power done");
		wb(UBR_ADDR_MODE, 1'b1, 8'ha0);
		wb(UBR_ADDR_DIVIDER, 1'b1, 8'h48);
		send(16'h41, 11'h74c);
		send(16'h3f, 11'h4b2);
		send(16'h40, 11'h2b4);
		$display("test receive done");
		tally_and_finish();
	end
endmodule : ubr_core_tb_top
`default_nettype wire
